// [logic/pgaci_pkg.sv]
/*
 Constants, types and helpers for the amplifier control port.
 Assumes a single core clock; all pins are sampled and synchronised by the user module.
*/
// Overview of operation
// - Level pins choose serial or parallel mode
// - Parallel mode uses pins, ignores control word
// - Parallel gain decode sets bandwidth trim automatically
// - Fault detection disabled in parallel mode
// - Serial mode: 16-bit word governs settings
// - Gain bits 0-2, trim bits 3-5
// - Route 6-7, swap 8, power-down 9, filter 10
// - Bit 11 picks fault test pin
// - Test level bits 12-14, bit 15 zero
// - Shift stage then holding stage, no glitches
// - Data in, shifted-out bit on data out
// - Shifting enabled only after select falls
// - Sample one bit per rising clock edge
// - Select rising copies shift into holding stage
// - Both stages cleared to zero at reset
// - Chained frames push contents on, farthest first
// - Data out driven only while select low
// - Test level 1 to 5 picks strength
package pgaci_pkg;
   localparam int WORD_W = 16;
   localparam int SYNC_N = 6;
   // Pin vector positions
   localparam int PIN_MODE_A = 0;
   localparam int PIN_MODE_B = 1;
   localparam int PIN_CS_N = 2;
   localparam int PIN_SCK = 3;
   localparam int PIN_SDI = 4;
   localparam int PIN_G0 = 5;
   // Idle pin levels after reset: select high, clock high
   localparam logic [SYNC_N-1:0] PIN_IDLE = 6'h0c;
   // Control word field positions
   localparam int GAIN_LSB = 0;
   localparam int BW_LSB = 3;
   localparam int ROUTE_LSB = 6;
   localparam int SWAP_BIT = 8;
   localparam int PD_BIT = 9;
   localparam int EXTERNAL_CAP_LOWPASS_EN_BIT = 10;
   localparam int FPIN_BIT = 11;
   localparam int LEVEL_LSB = 12;
   localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
   localparam logic MODE_RESET = 1'b0;
   localparam logic [2:0] GAIN_EXT = 3'h7;
   localparam int LEVEL_N = 5;
   localparam logic [4:0] CNT_FULL = 5'h10;

   typedef struct packed {
      logic serial_mode;
      logic [2:0] gain_code;
      logic ext_gain_res;
      logic [2:0] bw_trim;
      logic [1:0] input_route_select;
      logic input_sign_swap;
      logic power_down;
      logic external_cap_lowpass_en;
      logic fault_pin_sel;
      logic [2:0] fault_test_level;
      logic fault_detect_en;
      logic [LEVEL_N-1:0] fault_test_strength;
   } pgaci_set_t;

   function automatic logic [2:0] pgaci_auto_bw(input logic [2:0] gain);
      unique case (gain)
         3'h0, 3'h1: pgaci_auto_bw = 3'h0;
         3'h2: pgaci_auto_bw = 3'h1;
         3'h3, 3'h4: pgaci_auto_bw = 3'h2;
         3'h5, 3'h6: pgaci_auto_bw = 3'h3;
         3'h7: pgaci_auto_bw = 3'h4;
      endcase
   endfunction
endpackage

// [logic/pgaci_top.sv]
/*
 Control port of a programmable-gain amplifier: mode select, parallel pins,
 double-buffered serial control word with chain output.
 Assumes all pin inputs are asynchronous to i_core_clk and that the serial
 clock is much slower than the core clock, so its edges are found by sampling.
*/
`timescale 1ns/100ps
`default_nettype none
module pgaci_top (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_mode_level_pin_a,
   input wire logic i_mode_level_pin_b,
   input wire logic i_chip_select_n,
   input wire logic i_serial_clk,
   input wire logic i_serial_din,
   input wire logic i_serial_dout_in,
   output logic o_serial_dout,
   output logic o_serial_dout_oe,
   output pgaci_pkg::pgaci_set_t o_settings,
   output logic [pgaci_pkg::WORD_W-1:0] o_control_word
);
   import pgaci_pkg::*;

   // ***************************************
   // Pin synchronisers
   // ***************************************
   logic [SYNC_N-1:0] pin_raw;
   logic [SYNC_N-1:0] pin_meta;
   logic [SYNC_N-1:0] pin_sync;
   assign pin_raw = {i_serial_dout_in, i_serial_din, i_serial_clk,
                     i_chip_select_n, i_mode_level_pin_b, i_mode_level_pin_a};

   genvar p;
   generate
      for (p = 0; p < SYNC_N; p++) begin : g_sync
         always_ff @(posedge i_core_clk) begin
            if (!i_rst_n) begin
               pin_meta[p] <= PIN_IDLE[p];
               pin_sync[p] <= PIN_IDLE[p];
            end else begin
               pin_meta[p] <= pin_raw[p];
               pin_sync[p] <= pin_meta[p];
            end
         end
      end
   endgenerate

   logic mode_a;
   logic mode_b;
   logic cs_n;
   logic sck;
   logic sdi;
   logic g0;
   assign mode_a = pin_sync[PIN_MODE_A];
   assign mode_b = pin_sync[PIN_MODE_B];
   assign cs_n = pin_sync[PIN_CS_N];
   assign sck = pin_sync[PIN_SCK];
   assign sdi = pin_sync[PIN_SDI];
   assign g0 = pin_sync[PIN_G0];

   // ***************************************
   // Mode selection
   // ***************************************
   logic serial_mode;
   // Equal levels are not a legal setting; the last mode is kept
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         serial_mode <= MODE_RESET;
      end else if (!mode_a && mode_b) begin
         serial_mode <= 1'b1;
      end else if (mode_a && !mode_b) begin
         serial_mode <= 1'b0;
      end
   end

   // ***************************************
   // Edge detection
   // ***************************************
   logic cs_q;
   logic sck_q;
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         cs_q <= PIN_IDLE[PIN_CS_N];
         sck_q <= PIN_IDLE[PIN_SCK];
      end else begin
         cs_q <= cs_n;
         sck_q <= sck;
      end
   end

   logic cs_fall;
   logic cs_rise;
   logic sck_rise;
   logic sck_fall;
   // Select edges are clean because the host holds the clock high there
   assign cs_fall = cs_q && !cs_n;
   assign cs_rise = !cs_q && cs_n;
   assign sck_rise = !sck_q && sck;
   assign sck_fall = sck_q && !sck;

   // ***************************************
   // Serial frame
   // ***************************************
   logic frame_en;
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         frame_en <= 1'b0;
      end else if (!serial_mode || cs_rise) begin
         frame_en <= 1'b0;
      end else if (cs_fall) begin
         frame_en <= 1'b1;
      end
   end

   logic shift_take;
   assign shift_take = frame_en && !cs_n && sck_rise;

   logic [WORD_W-1:0] shift_word;
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         shift_word <= WORD_RESET;
      end else if (shift_take) begin
         // Oldest bit leaves at the top and feeds the next device
         shift_word <= {shift_word[WORD_W-2:0], sdi};
      end
   end

   logic [4:0] bit_cnt;
   // Counts rising edges; a short frame is still transferred
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n || cs_fall) begin
         bit_cnt <= 5'h00;
      end else if (shift_take && bit_cnt != 5'h1f) begin
         bit_cnt <= bit_cnt + 5'h01;
      end
   end

   logic load;
   assign load = serial_mode && frame_en && cs_rise;

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         o_control_word <= WORD_RESET;
      end else if (load) begin
         o_control_word <= shift_word;
      end
   end

   // ***************************************
   // Serial data output
   // ***************************************
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         o_serial_dout <= 1'b0;
      end else if (cs_fall || (frame_en && sck_fall)) begin
         o_serial_dout <= shift_word[WORD_W-1];
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         o_serial_dout_oe <= 1'b0;
      end else begin
         o_serial_dout_oe <= serial_mode && !cs_n;
      end
   end

   // ***************************************
   // Active settings
   // ***************************************
   logic [LEVEL_N-1:0] strength_dec;
   genvar k;
   generate
      for (k = 0; k < LEVEL_N; k++) begin : g_level
         assign strength_dec[k] =
            o_control_word[LEVEL_LSB +: 3] == 3'(k + 1);
      end
   endgenerate

   pgaci_set_t next_settings;
   always_comb begin
      next_settings = '0;
      next_settings.serial_mode = serial_mode;
      if (serial_mode) begin
         // Bit 15 carries nothing and is ignored
         next_settings.gain_code = o_control_word[GAIN_LSB +: 3];
         next_settings.bw_trim = o_control_word[BW_LSB +: 3];
         next_settings.input_route_select = o_control_word[ROUTE_LSB +: 2];
         next_settings.input_sign_swap = o_control_word[SWAP_BIT];
         next_settings.power_down = o_control_word[PD_BIT];
         next_settings.external_cap_lowpass_en = o_control_word[EXTERNAL_CAP_LOWPASS_EN_BIT];
         next_settings.fault_pin_sel = o_control_word[FPIN_BIT];
         next_settings.fault_test_level = o_control_word[LEVEL_LSB +: 3];
         next_settings.fault_test_strength = strength_dec;
         next_settings.fault_detect_en = |strength_dec;
      end else begin
         // Control word kept but unused; fault logic stays off
         next_settings.gain_code = {sck, sdi, g0};
         next_settings.bw_trim = pgaci_auto_bw({sck, sdi, g0});
         next_settings.power_down = cs_n;
      end
      next_settings.ext_gain_res = next_settings.gain_code == GAIN_EXT;
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         o_settings <= '0;
      end else begin
         o_settings <= next_settings;
      end
   end

   // ***************************************
   // Assertions
   // ***************************************
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rst_n);

   mode_serial_a: assert property (!mode_a && mode_b |=> serial_mode)
      else $error("serial mode not taken");
   mode_par_a: assert property (mode_a && !mode_b |=> !serial_mode)
      else $error("parallel mode not taken");
   par_gain_a: assert property (!serial_mode |=>
         o_settings.gain_code == $past({sck, sdi, g0}) &&
         o_settings.power_down == $past(cs_n))
      else $error("parallel pins not followed");
   // Automatic trim, one step of the gain table each
   trim_zero_a: assert property (!o_settings.serial_mode &&
         o_settings.gain_code inside {3'h0, 3'h1} |-> o_settings.bw_trim == 3'h0)
      else $error("wrong automatic trim for low gain");
   trim_one_a: assert property (!o_settings.serial_mode &&
         o_settings.gain_code == 3'h2 |-> o_settings.bw_trim == 3'h1)
      else $error("wrong automatic trim for gain code 2");
   par_trim_a: assert property (!o_settings.serial_mode &&
         o_settings.gain_code == 3'h3 |-> o_settings.bw_trim == 3'h2)
      else $error("wrong automatic trim");
   trim_two_a: assert property (!o_settings.serial_mode &&
         o_settings.gain_code == 3'h4 |-> o_settings.bw_trim == 3'h2)
      else $error("wrong automatic trim for gain code 4");
   trim_three_a: assert property (!o_settings.serial_mode &&
         o_settings.gain_code inside {3'h5, 3'h6} |-> o_settings.bw_trim == 3'h3)
      else $error("wrong automatic trim for high gain");
   trim_ext_a: assert property (!o_settings.serial_mode &&
         o_settings.gain_code == 3'h7 |-> o_settings.bw_trim[2])
      else $error("wrong automatic trim for external gain");
   ext_flag_a: assert property (o_settings.ext_gain_res ==
         (o_settings.gain_code == GAIN_EXT))
      else $error("external gain flag wrong");
   fault_off_a: assert property (!o_settings.serial_mode |->
         !o_settings.fault_detect_en && o_settings.fault_test_strength == '0)
      else $error("fault logic on in parallel mode");
   field_map_a: assert property (serial_mode |=>
         o_settings.bw_trim == $past(o_control_word[5:3]) &&
         o_settings.fault_pin_sel == $past(o_control_word[11]) &&
         o_settings.fault_test_level == $past(o_control_word[14:12]))
      else $error("control field misplaced");
   gain_map_a: assert property (serial_mode |=>
         o_settings.gain_code == $past(o_control_word[2:0]))
      else $error("gain field misplaced");
   route_map_a: assert property (serial_mode |=>
         o_settings.input_route_select == $past(o_control_word[7:6]) &&
         o_settings.input_sign_swap == $past(o_control_word[8]) &&
         o_settings.power_down == $past(o_control_word[9]) &&
         o_settings.external_cap_lowpass_en == $past(o_control_word[10]))
      else $error("routing field misplaced");
   hold_stable_a: assert property (!load |=> $stable(o_control_word))
      else $error("holding stage changed mid frame");
   shift_idle_a: assert property (!frame_en |=> $stable(shift_word))
      else $error("shift outside frame");
   frame_open_a: assert property (serial_mode && cs_fall |=> frame_en)
      else $error("frame not opened on select fall");
   shift_in_a: assert property (shift_take |=>
         shift_word[0] == $past(sdi) &&
         shift_word[15:1] == $past(shift_word[14:0]))
      else $error("bit not shifted in");
   load_a: assert property (load |=> o_control_word == $past(shift_word))
      else $error("word not transferred");
   dout_first_a: assert property (cs_fall |=> o_serial_dout == $past(shift_word[15]))
      else $error("first data out bit wrong");
   sdo_fall_a: assert property (frame_en && sck_fall |=>
         o_serial_dout == $past(shift_word[15]))
      else $error("data out not updated on falling edge");
   oe_idle_a: assert property (cs_n |=> !o_serial_dout_oe)
      else $error("data out driven while deselected");
   oe_drive_a: assert property (serial_mode && !cs_n |=> o_serial_dout_oe)
      else $error("data out not driven while selected");
   level_dec_a: assert property (o_settings.serial_mode &&
         o_settings.fault_test_level inside {[3'h1:3'h5]} |->
         o_settings.fault_detect_en &&
         o_settings.fault_test_strength == (5'h01 << (o_settings.fault_test_level - 3'h1)))
      else $error("test level not decoded");
   level_off_a: assert property (!(o_settings.fault_test_level inside {[3'h1:3'h5]}) |->
         !o_settings.fault_detect_en && o_settings.fault_test_strength == '0)
      else $error("test source on for unused level");
   reset_clear_a: assert property (disable iff (1'b0)
         !i_rst_n |=> o_control_word == '0 && shift_word == '0)
      else $error("stages not cleared at reset");

   full_frame_c: cover property (load && bit_cnt == CNT_FULL);
   short_frame_c: cover property (load && bit_cnt < CNT_FULL);
   ext_gain_c: cover property (!serial_mode && {sck, sdi, g0} == GAIN_EXT);
   mode_swap_c: cover property (serial_mode ##1 !serial_mode);
   level_set_c: cover property (o_settings.fault_detect_en);
endmodule
`default_nettype wire

// [sim/pgaci_host.sv]
/*
 Host model that drives the amplifier's mode, select, clock and data pins.
 Assumes the bench feeds it the core clock; pins move 1 ns after its rising edge.
*/
`timescale 1ns/100ps
`default_nettype none
module pgaci_host (
   input wire logic i_clk,
   output logic o_mode_a,
   output logic o_mode_b,
   output logic o_cs_n,
   output logic o_sck,
   output logic o_sdi,
   output logic o_g0,
   output logic o_g0_en
);
   // ****************
   // Pin sequencing
   // ****************
   initial begin
      o_mode_a = 1'b1;
      o_mode_b = 1'b0;
      o_cs_n = 1'b1;
      o_sck = 1'b1;
      o_sdi = 1'b0;
      o_g0 = 1'b0;
      o_g0_en = 1'b1;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask

   // Host lets go of the gain LSB pin in serial mode
   task automatic set_mode(input logic serial);
      o_mode_a = !serial;
      o_mode_b = serial;
      o_g0_en = !serial;
      tick(4);
   endtask

   // Clock idles high across both select edges; this select is shared by every device in the chain
   task automatic select_low();
      o_cs_n = 1'b0;
      tick(8);
   endtask

   // Released data line shows the inverse of its last value
   task automatic select_high();
      tick(7);
      o_cs_n = 1'b1;
      o_sdi = ~o_sdi;
      tick(8);
   endtask

   // 64 ns link clock period, data set while the clock is low
   task automatic put_bit(input logic b);
      o_sck = 1'b0;
      o_sdi = b;
      tick(4);
      o_sck = 1'b1;
      tick(4);
   endtask

   task automatic par(input logic [2:0] g, input logic pd);
      o_cs_n = pd;
      o_sck = g[2];
      o_sdi = g[1];
      o_g0 = g[0];
      tick(6);
   endtask
endmodule
`default_nettype wire

// [sim/pga_control_interface_tb.sv]
/*
 Self-checking bench for the amplifier control port.
 Assumes pgaci_pkg and the host model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module pga_control_interface_tb;
   import pgaci_pkg::*;
   logic clk;
   logic rst_n;
   logic mode_a, mode_b, cs_n, sck, sdi, g0, g0_en, dout, dout_oe, pin;
   logic pin_q = 1'b0;
   pgaci_set_t set;
   logic [15:0] word;
   logic [15:0] cap = 16'h0;
   logic [15:0] sh = 16'h0;
   logic [15:0] hold = 16'h0;
   logic [2:0] bw_tab [8] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h4};
   int miscompares = 0;
   int n_compared = 0;
   int cycles = 0;

   assign pin = dout_oe ? dout : (g0_en ? g0 : ~pin_q);

   pgaci_top pgaci_top_i (.i_core_clk(clk), .i_rst_n(rst_n), .i_mode_level_pin_a(mode_a),
      .i_mode_level_pin_b(mode_b), .i_chip_select_n(cs_n), .i_serial_clk(sck),
      .i_serial_din(sdi), .i_serial_dout_in(pin), .o_serial_dout(dout),
      .o_serial_dout_oe(dout_oe), .o_settings(set), .o_control_word(word));
   pgaci_host pgaci_host_i (.i_clk(clk), .o_mode_a(mode_a), .o_mode_b(mode_b), .o_cs_n(cs_n),
      .o_sck(sck), .o_sdi(sdi), .o_g0(g0), .o_g0_en(g0_en));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Downstream device view: data out sampled on each rising link clock while select is low
   always @(posedge sck) begin
      if (!cs_n) begin
         cap <= {cap[14:0], pin};
      end
   end

   always @(posedge clk) begin
      // Keep the last driven level so a released pin settles to its inverse
      if (dout_oe || g0_en) begin
         pin_q <= pin;
      end
      cycles <= cycles + 1;
      if (cycles == 10000) begin
         miscompares++;
         test_done();
      end
   end

   // ****************
   // Checks
   // ****************
   task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp_set(input pgaci_set_t got, input pgaci_set_t exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   function automatic pgaci_set_t exp_ser(input logic [15:0] w);
      pgaci_set_t e;
      logic ok;
      ok = (w[14:12] >= 3'h1) && (w[14:12] <= 3'h5);
      e = '0;
      e.serial_mode = 1'b1;
      e.gain_code = w[2:0];
      e.ext_gain_res = (w[2:0] == 3'h7);
      e.bw_trim = w[5:3];
      e.input_route_select = w[7:6];
      e.input_sign_swap = w[8];
      e.power_down = w[9];
      e.external_cap_lowpass_en = w[10];
      e.fault_pin_sel = w[11];
      e.fault_test_level = w[14:12];
      e.fault_detect_en = ok;
      e.fault_test_strength = ok ? 5'h1 << (w[14:12] - 3'h1) : 5'h0;
      return e;
   endfunction

   function automatic pgaci_set_t exp_par(input logic [2:0] g, input logic pd);
      pgaci_set_t e;
      e = '0;
      e.gain_code = g;
      e.ext_gain_res = (g == 3'h7);
      e.bw_trim = bw_tab[g];
      e.power_down = pd;
      return e;
   endfunction

   // Frames of fewer than 16 bits still move the shift stage on select rise
   task automatic frame(input logic [15:0] w, input int n);
      logic [15:0] old;
      old = sh;
      pgaci_host_i.select_low();
      for (int i = 0; i < n; i++) begin
         pgaci_host_i.put_bit(w[15 - i]);
         sh = {sh[14:0], w[15 - i]};
         if (i == 7) cmp_word(word, hold);
      end
      cmp_word({15'h0, dout_oe}, 16'h1);
      pgaci_host_i.select_high();
      hold = sh;
      cmp_word({15'h0, dout_oe}, 16'h0);
      cmp_word(word, hold);
      cmp_set(set, exp_ser(hold));
      if (n == 16) cmp_word(cap, old);
   endtask

   task automatic test_done();
      $display("compared %0d, miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ****************
   // Tests
   // ****************
   initial begin
      logic [2:0] lv;
      rst_n = 1'b0;
      repeat (5) @(posedge clk);
      #1;
      rst_n = 1'b1;
      pgaci_host_i.tick(3);
      cmp_word(word, 16'h0);
      // Idle host pins read as gain code 4 with power-down in parallel mode
      cmp_set(set, exp_par(3'h4, 1'b1));
      $display("test reset done");
      pgaci_host_i.set_mode(1'b1);
      cmp_set(set, exp_ser(16'h0));
      for (int k = 0; k < 8; k++) begin
         lv = 3'(k);
         // Bit 15 always sent as zero; first frame is the application write
         frame({1'b0, lv, ~lv[0], lv[0], lv[1], lv[2], lv[1:0], ~lv, lv ^ 3'h5}, 16);
      end
      $display("test serial fields done");
      frame(16'hab00, 8);
      for (int k = 0; k < 3; k++) begin
         pgaci_host_i.put_bit(1'b1);
      end
      frame(16'h0, 0);
      frame(16'h0013, 16);
      $display("test short frame and chain done");
      // Reset with a live word: both stages must clear
      rst_n = 1'b0;
      pgaci_host_i.tick(2);
      rst_n = 1'b1;
      sh = 16'h0;
      hold = 16'h0;
      pgaci_host_i.tick(5);
      cmp_word(word, 16'h0);
      cmp_set(set, exp_ser(16'h0));
      frame(16'h0005, 16);
      $display("test mid-run reset done");
      pgaci_host_i.set_mode(1'b0);
      for (int k = 0; k < 16; k++) begin
         pgaci_host_i.par(3'(k >> 1), k[0]);
         cmp_word({6'h0, set.serial_mode, set.gain_code, set.ext_gain_res, set.bw_trim,
            set.power_down, set.fault_detect_en}, {6'h0, 1'b0, 3'(k >> 1), (k >> 1) == 7,
            bw_tab[k >> 1], k[0], 1'b0});
         cmp_set(set, exp_par(3'(k >> 1), k[0]));
      end
      $display("test parallel done");
      test_done();
   end
endmodule
`default_nettype wire
